// ---- logic/gpls_port.v ----
// Functional notes
// - Output data byte0 at 0x48, reset zero
// - Enable one drives pin, zero input only
// - Select bit: zero shared function, one GPIO
// - Selection gates drivers only, input always sampled
// - LED enable bits switch pins 0..5 while GPIO is selected
// - Rotator maps line n to pin (n+rot)%4
// - Input registers return live pin levels
`timescale 1ns/10ps
`include "gpls_consts.vh"

module gpls_port (
  input wire clock,
  input wire resetn,
  // Avalon-MM slave, byte address
  input wire [9:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output reg [1:0] response,
  output reg waitrequest,
  // Pins 0..7, shared with the first functions
  input wire [7:0] pin_in_byte0,
  output reg [7:0] pin_out_byte0,
  output reg [7:0] pin_oe_byte0,
  // First functions in pin order 0..7
  input wire [7:0] first_func_out,
  input wire [7:0] first_func_oe,
  // Pins 16..23
  input wire [7:0] pin_in_byte2,
  output reg [7:0] pin_out_byte2,
  output reg [7:0] pin_oe_byte2,
  // Pins 8..15 and 24..31, input side only here
  input wire [7:0] pin_in_byte1,
  input wire [7:0] pin_in_byte3,
  // Activated state of line interfaces 0..3
  input wire [3:0] line_active_state
);

  // Bus handshake state, one-hot
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_ACK = 2'b10;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;

  // Software registers
  reg [7:0] pin_output_byte0_ff;
  reg [7:0] pin_output_byte2_ff;
  reg [7:0] pin_drive_enable_byte0_ff;
  reg [7:0] pin_drive_enable_byte2_ff;
  reg [7:0] pin_function_select_ff;
  reg [7:0] led_state_control_ff;

  // Bus decode
  wire [`GPLS_IDX_W-1:0] reg_index;
  wire req_any;
  wire wr_take;
  wire wr_lane0;
  reg [7:0] rd_byte;
  reg rd_hit;
  wire rd_start;
  wire wr_start;

  // One strobe per writable register
  wire wr_output_byte0;
  wire wr_output_byte2;
  wire wr_drive_enable_byte0;
  wire wr_drive_enable_byte2;
  wire wr_function_select;
  wire wr_led_state_control;

  // Answer loaded into readdata and response as waitrequest falls
  reg [31:0] nxt_readdata;
  reg [1:0] nxt_response;
  wire ack_next;

  // LED routing
  wire [5:0] led_indicate_enable_bit;
  wire [1:0] led_rotate_field;
  wire [3:0] led_level;
  wire [5:0] led_pin_level;

  // Per-pin next values for the driven pins
  wire [7:0] nxt_pin_out_byte0;
  wire [7:0] nxt_pin_oe_byte0;
  wire [7:0] nxt_pin_out_byte2;
  wire [7:0] nxt_pin_oe_byte2;

  assign reg_index = address[9:2];
  assign req_any = read | write;
  // Write lands at the edge where waitrequest is seen low
  assign wr_take = write & (state_ff == ST_ACK);
  assign wr_lane0 = wr_take & byteenable[0];

  // A new request is taken only while idle
  assign rd_start = read & (state_ff == ST_IDLE);
  assign wr_start = write & (state_ff == ST_IDLE);

  // One decode per writable register; only lane 0 carries data
  assign wr_output_byte0 = wr_lane0 & (reg_index == `GPLS_IDX_OUTPUT_BYTE0);
  assign wr_output_byte2 = wr_lane0 & (reg_index == `GPLS_IDX_OUTPUT_BYTE2);
  assign wr_drive_enable_byte0 = wr_lane0 & (reg_index == `GPLS_IDX_DRIVE_EN_BYTE0);
  assign wr_drive_enable_byte2 = wr_lane0 & (reg_index == `GPLS_IDX_DRIVE_EN_BYTE2);
  assign wr_function_select = wr_lane0 & (reg_index == `GPLS_IDX_FUNC_SELECT);
  assign wr_led_state_control = wr_lane0 & (reg_index == `GPLS_IDX_LED_CTRL);

  assign led_indicate_enable_bit = led_state_control_ff[`GPLS_LED_EN_MSB:`GPLS_LED_EN_LSB];
  assign led_rotate_field = led_state_control_ff[`GPLS_LED_ROT_MSB:`GPLS_LED_ROT_LSB];

  // Handshake: one cycle of wait, then one cycle of answer
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (req_any) begin
          nxt_state = ST_ACK;
        end
      end
      ST_ACK: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clock) begin
    if (!resetn) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Answer cycle follows every taken request
  assign ack_next = (nxt_state == ST_ACK);

  // Waitrequest held high except in the answer cycle
  always @(posedge clock) begin
    if (!resetn) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= ~ack_next;
    end
  end

  // Read decode: only input registers are readable
  always @* begin
    rd_byte = 8'h00;
    rd_hit = 1'b0;
    case (reg_index)
      `GPLS_IDX_INPUT_BYTE1: begin
        rd_byte = pin_in_byte1;
        rd_hit = 1'b1;
      end
      `GPLS_IDX_INPUT_BYTE3: begin
        rd_byte = pin_in_byte3;
        rd_hit = 1'b1;
      end
      `GPLS_IDX_INPUT_BYTE2: begin
        rd_byte = pin_in_byte2;
        rd_hit = 1'b1;
      end
      `GPLS_IDX_INPUT_BYTE0: begin
        rd_byte = pin_in_byte0;
        rd_hit = 1'b1;
      end
      default: begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Write decode: which offsets accept a write
  function wr_mapped;
    input [`GPLS_IDX_W-1:0] idx;
    begin
      case (idx)
        `GPLS_IDX_OUTPUT_BYTE2: wr_mapped = 1'b1;
        `GPLS_IDX_DRIVE_EN_BYTE2: wr_mapped = 1'b1;
        `GPLS_IDX_OUTPUT_BYTE0: wr_mapped = 1'b1;
        `GPLS_IDX_DRIVE_EN_BYTE0: wr_mapped = 1'b1;
        `GPLS_IDX_FUNC_SELECT: wr_mapped = 1'b1;
        `GPLS_IDX_LED_CTRL: wr_mapped = 1'b1;
        default: wr_mapped = 1'b0;
      endcase
    end
  endfunction

  // Answer for the request being taken; zero outside answer cycles
  always @* begin
    nxt_readdata = 32'h00000000;
    nxt_response = `GPLS_RESP_OKAY;
    if (rd_start) begin
      // Input bytes read live, whatever the select and enables
      nxt_readdata = {24'h000000, rd_byte};
      if (!rd_hit) begin
        nxt_response = `GPLS_RESP_SLVERR;
      end
    end else if (wr_start) begin
      // Writes answer with a response code only
      if (!wr_mapped(reg_index)) begin
        nxt_response = `GPLS_RESP_SLVERR;
      end
    end
  end

  // Read data and response, loaded as waitrequest falls
  always @(posedge clock) begin
    if (!resetn) begin
      readdata <= 32'h00000000;
      response <= `GPLS_RESP_OKAY;
    end else begin
      readdata <= nxt_readdata;
      response <= nxt_response;
    end
  end

  // Output data byte for pins 0..7
  always @(posedge clock) begin
    if (!resetn) begin
      pin_output_byte0_ff <= `GPLS_RST_OUTPUT;
    end else if (wr_output_byte0) begin
      pin_output_byte0_ff <= writedata[7:0];
    end
  end

  // Output data byte for pins 16..23
  always @(posedge clock) begin
    if (!resetn) begin
      pin_output_byte2_ff <= `GPLS_RST_OUTPUT;
    end else if (wr_output_byte2) begin
      pin_output_byte2_ff <= writedata[7:0];
    end
  end

  // Output enables for pins 0..7, reset to zero; after reset the pins follow first_func_oe until GPIO is selected
  always @(posedge clock) begin
    if (!resetn) begin
      pin_drive_enable_byte0_ff <= `GPLS_RST_DRIVE_EN;
    end else if (wr_drive_enable_byte0) begin
      pin_drive_enable_byte0_ff <= writedata[7:0];
    end
  end

  // Output enables for pins 16..23, all drivers off after reset
  always @(posedge clock) begin
    if (!resetn) begin
      pin_drive_enable_byte2_ff <= `GPLS_RST_DRIVE_EN;
    end else if (wr_drive_enable_byte2) begin
      pin_drive_enable_byte2_ff <= writedata[7:0];
    end
  end

  // Function selection of pins 0..7
  always @(posedge clock) begin
    if (!resetn) begin
      pin_function_select_ff <= `GPLS_RST_FUNC_SELECT;
    end else if (wr_function_select) begin
      pin_function_select_ff <= writedata[7:0];
    end
  end

  // LED enables and rotator setting
  always @(posedge clock) begin
    if (!resetn) begin
      led_state_control_ff <= `GPLS_RST_LED_CTRL;
    end else if (wr_led_state_control) begin
      led_state_control_ff <= writedata[7:0];
    end
  end

  // Pin numbers 3..0 as two-bit codes, for the mod 4 rotator
  localparam [7:0] PIN_CODES = 8'hE4;

  // Rotator: pin q shows line (q - rot) mod 4
  genvar q;
  generate
    for (q = 0; q < 4; q = q + 1) begin : g_rot
      wire [1:0] line_sel;
      // Two-bit difference wraps, which gives the mod 4
      assign line_sel = PIN_CODES[2*q +: 2] - led_rotate_field;
      assign led_level[q] = line_active_state[line_sel];
    end
  endgenerate

  // LED source per pin; pins 4 and 5 repeat pins 0 and 1
  genvar k;
  generate
    for (k = 0; k < 6; k = k + 1) begin : g_led_src
      assign led_pin_level[k] = led_level[k % 4];
    end
  endgenerate

  // Per-pin driver path for pins 0..7
  genvar p;
  generate
    for (p = 0; p < 8; p = p + 1) begin : g_pin
      wire gpio_level;
      if (p < 6) begin : g_led
        // LED state replaces only the data, the enable still applies
        assign gpio_level = led_indicate_enable_bit[p] ? led_pin_level[p]
          : pin_output_byte0_ff[p];
      end else begin : g_plain
        assign gpio_level = pin_output_byte0_ff[p];
      end
      // Selection steers only the driver, never the input path
      assign nxt_pin_out_byte0[p] = (pin_function_select_ff[p] == `GPLS_SEL_GPIO)
        ? gpio_level : first_func_out[p];
      assign nxt_pin_oe_byte0[p] = (pin_function_select_ff[p] == `GPLS_SEL_GPIO)
        ? pin_drive_enable_byte0_ff[p] : first_func_oe[p];
    end
  endgenerate

  // Pins 16..23 driven straight from their data and enable bytes
  assign nxt_pin_out_byte2 = pin_output_byte2_ff;
  assign nxt_pin_oe_byte2 = pin_drive_enable_byte2_ff;

  // Pin outputs of pins 0..7 registered
  always @(posedge clock) begin
    if (!resetn) begin
      pin_out_byte0 <= `GPLS_RST_OUTPUT;
      pin_oe_byte0 <= `GPLS_RST_DRIVE_EN;
    end else begin
      pin_out_byte0 <= nxt_pin_out_byte0;
      pin_oe_byte0 <= nxt_pin_oe_byte0;
    end
  end

  // Pin outputs of pins 16..23 registered
  always @(posedge clock) begin
    if (!resetn) begin
      pin_out_byte2 <= `GPLS_RST_OUTPUT;
      pin_oe_byte2 <= `GPLS_RST_DRIVE_EN;
    end else begin
      pin_out_byte2 <= nxt_pin_out_byte2;
      pin_oe_byte2 <= nxt_pin_oe_byte2;
    end
  end

endmodule // gpls_port

// ---- logic/gpls_consts.vh ----
`ifndef GPLS_CONSTS_VH
`define GPLS_CONSTS_VH

// Register indices; byte address on the bus is four times the index
`define GPLS_IDX_W 8
`define GPLS_IDX_INPUT_BYTE1 8'h40
`define GPLS_IDX_INPUT_BYTE3 8'h41
`define GPLS_IDX_INPUT_BYTE2 8'h45
`define GPLS_IDX_OUTPUT_BYTE2 8'h45
`define GPLS_IDX_DRIVE_EN_BYTE2 8'h47
`define GPLS_IDX_OUTPUT_BYTE0 8'h48
`define GPLS_IDX_INPUT_BYTE0 8'h48
`define GPLS_IDX_DRIVE_EN_BYTE0 8'h4A
`define GPLS_IDX_FUNC_SELECT 8'h4C
`define GPLS_IDX_LED_CTRL 8'h4D

// Reset values of the writable registers
`define GPLS_RST_OUTPUT 8'h00
`define GPLS_RST_DRIVE_EN 8'h00
`define GPLS_RST_FUNC_SELECT 8'h00
`define GPLS_RST_LED_CTRL 8'h00

// Field layout of the LED control register
`define GPLS_LED_EN_LSB 0
`define GPLS_LED_EN_MSB 5
`define GPLS_LED_ROT_LSB 6
`define GPLS_LED_ROT_MSB 7

// Function selection bit values
`define GPLS_SEL_FIRST 1'b0
`define GPLS_SEL_GPIO 1'b1

// Avalon response codes
`define GPLS_RESP_OKAY 2'h0
`define GPLS_RESP_SLVERR 2'h2

`endif

// ---- test/gpls_port_chk.sv ----
`timescale 1ns/10ps
module gpls_port_chk (
  input wire clock,
  input wire resetn,
  input wire [9:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [31:0] readdata,
  input wire [1:0] response,
  input wire waitrequest,
  input wire [7:0] pin_in_byte0,
  input wire [7:0] pin_out_byte0,
  input wire [7:0] pin_oe_byte0,
  input wire [7:0] first_func_out,
  input wire [7:0] pin_out_byte2
);
  wire [7:0] idx = address[9:2];
  wire wr_ok = write && !waitrequest;
  reg [7:0] sel_ff;
  // Shadow of the function select
  always @(posedge clock) begin
    if (!resetn) sel_ff <= 8'h00;
    else if (wr_ok && idx == 8'h4C) sel_ff <= writedata[7:0];
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_req;
    (read || write) && waitrequest;
  endsequence
  // Answer: low for one cycle, then high again
  sequence s_ack_pulse;
    !waitrequest ##1 waitrequest;
  endsequence
  a_wait_one: assert property (s_req |=> s_ack_pulse) else $error("wait");
  a_idle_zero: assert property (waitrequest |-> !readdata && !response) else $error("idle");
  a_bad_read: assert property ((s_req and (read && !(idx inside {8'h40, 8'h41, 8'h45, 8'h48})))
    |=> response == 2'h2 && !readdata) else $error("bad read");
  a_in_read: assert property ((s_req and (read && idx == 8'h48))
    |=> readdata == {24'h0, $past(pin_in_byte0)}) else $error("in read");
  a_bad_write: assert property ((s_req and
    (write && !(idx inside {8'h45, 8'h47, 8'h48, 8'h4A, 8'h4C, 8'h4D}))) |=> response == 2'h2)
    else $error("bad write");
  a_out2_set: assert property (wr_ok && idx == 8'h45
    |=> ##1 pin_out_byte2 == $past(writedata[7:0], 2)) else $error("out2");
  a_first_func: assert property ($past(resetn)
    |-> !((pin_out_byte0 ^ $past(first_func_out)) & ~$past(sel_ff))) else $error("func");
  a_reset_quiet: assert property ($rose(resetn)
    |-> !pin_oe_byte0 && !pin_out_byte2 && waitrequest) else $error("reset");
endmodule // gpls_port_chk
bind gpls_port gpls_port_chk u_chk (.clock(clock), .resetn(resetn), .address(address),
  .read(read), .write(write), .writedata(writedata), .readdata(readdata),
  .response(response), .waitrequest(waitrequest), .pin_in_byte0(pin_in_byte0),
  .pin_out_byte0(pin_out_byte0), .pin_oe_byte0(pin_oe_byte0),
  .first_func_out(first_func_out), .pin_out_byte2(pin_out_byte2));

// ---- test/gpls_pins.sv ----
`timescale 1ns/10ps
module gpls_pins (
  input wire [7:0] out0,
  input wire [7:0] oe0,
  input wire [7:0] ext0,
  input wire [7:0] out2,
  input wire [7:0] oe2,
  input wire [7:0] ext2,
  output wire [7:0] lvl0,
  output wire [7:0] lvl2
);
  // Driven bits show the driver, others the outside level
  assign lvl0 = (oe0 & out0) | (~oe0 & ext0);
  assign lvl2 = (oe2 & out2) | (~oe2 & ext2);
endmodule // gpls_pins

// ---- test/gpls_port_tb.sv ----
`timescale 1ns/10ps
module gpls_port_tb;
  reg clock = 1'b0;
  reg resetn = 1'b0;
  reg [9:0] address = 10'h000;
  reg read = 1'b0;
  reg write = 1'b0;
  reg [31:0] writedata = 32'h0;
  reg [7:0] ffo = 8'h00;
  reg [7:0] ffe = 8'h00;
  reg [3:0] line = 4'h3;
  wire [31:0] rdata;
  wire [1:0] resp;
  wire wait_req;
  wire [7:0] pin0, out0, oe0, pin2, out2, oe2;
  int fails = 0;
  int num_checks = 0;
  always #20 clock = ~clock;
  gpls_port uut (.clock(clock), .resetn(resetn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hF), .readdata(rdata), .response(resp),
    .waitrequest(wait_req), .pin_in_byte0(pin0), .pin_out_byte0(out0), .pin_oe_byte0(oe0),
    .first_func_out(ffo), .first_func_oe(ffe), .pin_in_byte2(pin2), .pin_out_byte2(out2),
    .pin_oe_byte2(oe2), .pin_in_byte1(8'h69), .pin_in_byte3(8'h1E), .line_active_state(line));
  gpls_pins u_pins (.out0(out0), .oe0(oe0), .ext0(8'hF0), .out2(out2), .oe2(oe2), .ext2(8'h3C),
    .lvl0(pin0), .lvl2(pin2));
  // Counts and reports one comparison
  task chk(input [33:0] got, input [33:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One bus transfer, answer judged at its sampling edge
  task bus(input w, input [7:0] idx, input [7:0] d, input [1:0] er);
    address <= {idx, 2'b00};
    read <= !w;
    write <= w;
    writedata <= {24'h0, d};
    // Held until waitrequest is seen low; only the watchdog ends a hang
    do begin
      @(posedge clock);
    end while (wait_req !== 1'b0);
    chk({resp, w ? 32'h0 : rdata}, {er, 24'h0, w ? 8'h00 : d});
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask
  task settle;
    repeat (3) @(posedge clock);
  endtask
  task t_reset;
    chk({oe0, oe2}, 0);
    chk(out2, 0);
    ffo <= 8'hA5;
    ffe <= 8'h3C;
    settle;
    chk({oe0, out0}, 16'h3CA5);
    bus(0, 8'h48, 8'hE4, 0);
  endtask
  task t_gpio;
    bus(1, 8'h4C, 8'hFF, 0);
    bus(1, 8'h4A, 8'h0F, 0);
    bus(1, 8'h48, 8'h5A, 0);
    settle;
    chk({oe0, out0}, 16'h0F5A);
    bus(0, 8'h48, 8'hFA, 0);
  endtask
  task t_regs;
    bus(1, 8'h47, 8'hC3, 0);
    bus(1, 8'h45, 8'h96, 0);
    settle;
    chk({oe2, out2}, 16'hC396);
    bus(0, 8'h45, 8'hBE, 0);
    bus(0, 8'h40, 8'h69, 0);
    bus(0, 8'h4C, 8'h00, 2);
    bus(1, 8'h41, 8'h77, 2);
    bus(1, 8'h47, 8'hFF, 0);
    settle;
    chk(oe2, 8'hFF);
    bus(0, 8'h45, 8'h96, 0);
  endtask
  task t_led;
    logic [3:0] p;
    for (int r = 0; r < 4; r++) begin
      for (int q = 0; q < 4; q++) p[q] = line[(q - r) & 3];
      bus(1, 8'h4D, {r[1:0], 6'h3F}, 0);
      settle;
      chk(out0, {2'b01, p[1:0], p});
    end
    bus(1, 8'h4D, 8'h01, 0);
    settle;
    chk(out0, 8'h5B);
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    t_reset;
    t_gpio;
    t_regs;
    t_led;
    print_verdict;
  end
  // Cuts a hang short
  initial begin
    #100000;
    fails++;
    print_verdict;
  end
  task print_verdict;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
endmodule // gpls_port_tb
